// ===== rtl/chs_health_status.sv
// Purpose: Builds the one-byte controller health summary and serves it over Avalon-MM.
// Assumes: Status inputs are asynchronous and pass two flip-flops first.
// Notes:   Summary changes set sticky event bits that can raise the interrupt.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "chs_regs.svh"

// Function
// - Bit 0 set on input supply fault.
// - Bit 1 set on output supply fault.
// - Bit 2 set on any standard error.
// - Two networks: bit 2 ORs both.
// - Bit 3 set when standard I/O runs.
// - Unestablished link keeps bit 3; errors clear.
// - Two networks: bit 3 ANDs both.
// - Bit 4 set on safety connection error.
// - Master only: bit 5 when masters normal.
// - Master and slave: also no slave error.
// - Bit 6 shows run mode.
// - Bit 7 clear on any listed error.
module chs_health_status (
  input  wire logic                core_clk_in,
  input  wire logic                rstn_in,
  input  wire chs_pkg::chs_addr_t  avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire chs_pkg::chs_word_t  avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output chs_pkg::chs_word_t       avs_readdata_out,
  output logic                     avs_waitrequest_out,
  input  wire logic                input_supply_ok_in,
  input  wire logic                output_supply_ok_in,
  input  wire logic [7:0]          std_a_estab_in,
  input  wire logic [7:0]          std_a_err_in,
  input  wire logic [7:0]          std_b_estab_in,
  input  wire logic [7:0]          std_b_err_in,
  input  wire logic [7:0]          saf_m_estab_in,
  input  wire logic [7:0]          saf_m_err_in,
  input  wire logic [7:0]          saf_s_err_in,
  input  wire logic                run_mode_in,
  input  wire logic [15:0]         error_detail_in,
  output chs_pkg::chs_byte_t       health_byte_out,
  output logic                     irq_out
);
  import chs_pkg::*;

  localparam int SYNC_W = 2 + 7 * `CHS_CONN_N + 1 + 16;

  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  chs_byte_t         summary_reg;
  chs_byte_t         summary_next;
  chs_byte_t         evt_stat_reg;
  chs_byte_t         evt_mask_reg;
  chs_byte_t         config_reg;
  chs_word_t         rdata_reg;
  logic              wait_reg;
  logic              irq_reg;
  chs_bus_state_t    bus_state_reg;
  logic [7:0]        s_a_est;
  logic [7:0]        s_a_err;
  logic [7:0]        s_b_est;
  logic [7:0]        s_b_err;
  logic [7:0]        s_m_est;
  logic [7:0]        s_m_err;
  logic [7:0]        s_s_err;
  logic              s_in_ok;
  logic              s_out_ok;
  logic              s_run;
  logic [15:0]       s_detail;
  logic              std_err_a;
  logic              std_err_b;
  logic              std_run_a;
  logic              std_run_b;
  logic              wr_fire;
  logic              rd_fire;
  logic [`CHS_SYNC_FILL-1:0] warm_reg;
  chs_byte_t         evt_set;
  logic              irq_next;

  // Progress on one network: some connection runs and none is in error.
  function automatic logic net_running(input logic [7:0] est, input logic [7:0] err);
    net_running = (|(est & ~err)) && !(|err);
  endfunction

  // Status pins are asynchronous and pass two flip-flops.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {input_supply_ok_in, output_supply_ok_in, std_a_estab_in, std_a_err_in,
                    std_b_estab_in, std_b_err_in, saf_m_estab_in, saf_m_err_in,
                    saf_s_err_in, run_mode_in, error_detail_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign {s_in_ok, s_out_ok, s_a_est, s_a_err, s_b_est, s_b_err, s_m_est, s_m_err,
          s_s_err, s_run, s_detail} = sync2_reg;

  assign std_err_a = |s_a_err;
  assign std_err_b = config_reg[`CHS_CFG_DUAL_NET] && (|s_b_err);
  assign std_run_a = net_running(s_a_est, s_a_err);
  assign std_run_b = !config_reg[`CHS_CFG_DUAL_NET] || net_running(s_b_est, s_b_err);

  always_comb begin
    summary_next = `CHS_RST_BYTE;
    summary_next[`CHS_BIT_IN_PWR]   = config_reg[`CHS_CFG_IN_USED] && !s_in_ok;
    summary_next[`CHS_BIT_OUT_PWR]  = config_reg[`CHS_CFG_OUT_USED] && !s_out_ok;
    summary_next[`CHS_BIT_STD_ERR]  = std_err_a || std_err_b;
    summary_next[`CHS_BIT_STD_RUN]  = std_run_a && std_run_b;
    summary_next[`CHS_BIT_SAF_ERR]  = (|s_m_err) ||
                                      (config_reg[`CHS_CFG_SLAVE_ON] && (|s_s_err));
    summary_next[`CHS_BIT_SAF_RUN]  = net_running(s_m_est, s_m_err) &&
                                      !(config_reg[`CHS_CFG_SLAVE_ON] && (|s_s_err));
    summary_next[`CHS_BIT_RUN_MODE] = s_run;
    summary_next[`CHS_BIT_NORMAL]   = !(|s_detail);
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      summary_reg <= `CHS_RST_BYTE;
    end else begin
      summary_reg <= summary_next;
    end
  end

  // Events stay quiet until the synchronisers and the summary hold real samples after reset.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      warm_reg <= '0;
    end else begin
      warm_reg <= {warm_reg[`CHS_SYNC_FILL-2:0], 1'b1};
    end
  end

  assign evt_set  = warm_reg[`CHS_SYNC_FILL-1] ? (summary_next ^ summary_reg) : `CHS_RST_BYTE;
  assign irq_next = |(evt_stat_reg & evt_mask_reg);

  assign wr_fire = avs_write_in && (bus_state_reg == CHS_BUS_ACK);
  assign rd_fire = avs_read_in && (bus_state_reg == CHS_BUS_ACK);

  // Every access waits one cycle, then completes with waitrequest low.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_state_reg <= CHS_BUS_IDLE;
      wait_reg      <= 1'b1;
    end else begin
      case (bus_state_reg)
        CHS_BUS_IDLE: begin
          if (avs_read_in || avs_write_in) begin
            bus_state_reg <= CHS_BUS_ACK;
            wait_reg      <= 1'b0;
          end
        end
        CHS_BUS_ACK: begin
          bus_state_reg <= CHS_BUS_IDLE;
          wait_reg      <= 1'b1;
        end
        default: begin
          bus_state_reg <= CHS_BUS_IDLE;
          wait_reg      <= 1'b1;
        end
      endcase
    end
  end

  // Read data is prepared with the acknowledge so it stands at the completing edge.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= `CHS_UNMAPPED;
    end else if (bus_state_reg == CHS_BUS_IDLE && avs_read_in) begin
      case (avs_address_in)
        `CHS_OFF_SUMMARY:  rdata_reg <= {24'h000000, summary_reg};
        `CHS_OFF_EVT_STAT: rdata_reg <= {24'h000000, evt_stat_reg};
        `CHS_OFF_EVT_MASK: rdata_reg <= {24'h000000, evt_mask_reg};
        `CHS_OFF_CONFIG:   rdata_reg <= {24'h000000, config_reg};
        default:           rdata_reg <= `CHS_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      config_reg   <= `CHS_RST_CFG;
      evt_mask_reg <= `CHS_RST_BYTE;
    end else if (wr_fire && avs_byteenable_in[0]) begin
      if (avs_address_in == `CHS_OFF_CONFIG) begin
        config_reg <= {4'h0, avs_writedata_in[3:0]};
      end
      if (avs_address_in == `CHS_OFF_EVT_MASK) begin
        evt_mask_reg <= avs_writedata_in[7:0];
      end
    end
  end

  // A bit of the summary that changes sets its sticky event; the set wins over the clear.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      evt_stat_reg <= `CHS_RST_BYTE;
    end else begin
      if (wr_fire && avs_byteenable_in[0] && avs_address_in == `CHS_OFF_EVT_STAT) begin
        evt_stat_reg <= (evt_stat_reg & ~avs_writedata_in[7:0]) | evt_set;
      end else begin
        evt_stat_reg <= evt_stat_reg | evt_set;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign health_byte_out     = summary_reg;
  assign avs_readdata_out    = rdata_reg;
  assign avs_waitrequest_out = wait_reg;
  assign irq_out             = irq_reg;

  property p_std_err;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (|s_a_err) |=> summary_reg[`CHS_BIT_STD_ERR];
  endproperty
  a_std_err: assert property (p_std_err) else $error("Standard error bit not set.");

  property p_dual_or;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (config_reg[`CHS_CFG_DUAL_NET] && (|s_b_err) && $stable(config_reg))
        |=> summary_reg[`CHS_BIT_STD_ERR];
  endproperty
  a_dual_or: assert property (p_dual_or) else $error("Second network error ignored.");

  property p_std_run_err;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (|s_a_err) |=> !summary_reg[`CHS_BIT_STD_RUN];
  endproperty
  a_std_run_err: assert property (p_std_run_err) else $error("Run bit set with error.");

  property p_saf_err;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (|s_m_err) |=> (summary_reg[`CHS_BIT_SAF_ERR] && !summary_reg[`CHS_BIT_SAF_RUN]);
  endproperty
  a_saf_err: assert property (p_saf_err) else $error("Safety error not reflected.");

  property p_slave_err;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (config_reg[`CHS_CFG_SLAVE_ON] && (|s_s_err) && $stable(config_reg))
        |=> !summary_reg[`CHS_BIT_SAF_RUN];
  endproperty
  a_slave_err: assert property (p_slave_err) else $error("Slave error kept run bit.");

  property p_run_mode;
    @(posedge core_clk_in) disable iff (!rstn_in)
      s_run |=> summary_reg[`CHS_BIT_RUN_MODE];
  endproperty
  a_run_mode: assert property (p_run_mode) else $error("Run mode late.");

  property p_normal;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (|s_detail) |=> !summary_reg[`CHS_BIT_NORMAL];
  endproperty
  a_normal: assert property (p_normal) else $error("Normal bit with error.");

  property p_in_pwr;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (!config_reg[`CHS_CFG_IN_USED] && $stable(config_reg)) |=> !summary_reg[`CHS_BIT_IN_PWR];
  endproperty
  a_in_pwr: assert property (p_in_pwr) else $error("Unused input supply flagged.");

  property p_out_pwr;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (config_reg[`CHS_CFG_OUT_USED] && !s_out_ok && $stable(config_reg))
        |=> summary_reg[`CHS_BIT_OUT_PWR];
  endproperty
  a_out_pwr: assert property (p_out_pwr) else $error("Output supply fault missed.");

  property p_bus_ack;
    @(posedge core_clk_in) disable iff (!rstn_in)
      ((avs_read_in || avs_write_in) && bus_state_reg == CHS_BUS_IDLE) |=> !avs_waitrequest_out;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("Bus answer not after one cycle.");

  property p_irq_on;
    @(posedge core_clk_in) disable iff (!rstn_in)
      irq_next |=> irq_out;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("Interrupt not raised.");

  property p_irq_off;
    @(posedge core_clk_in) disable iff (!rstn_in)
      !irq_next |=> !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("Interrupt without unmasked event.");

  property p_evt_set;
    @(posedge core_clk_in) disable iff (!rstn_in)
      (|evt_set) |=> ((evt_stat_reg & $past(evt_set)) == $past(evt_set));
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("Event lost to a clear.");

  c_std_run: cover property (@(posedge core_clk_in) summary_reg[`CHS_BIT_STD_RUN]);
  c_saf_run: cover property (@(posedge core_clk_in) summary_reg[`CHS_BIT_SAF_RUN]);
  c_irq:     cover property (@(posedge core_clk_in) irq_out);
  c_read:    cover property (@(posedge core_clk_in) rd_fire);
  c_dual:    cover property (@(posedge core_clk_in)
                             config_reg[`CHS_CFG_DUAL_NET] && summary_reg[`CHS_BIT_STD_RUN]);
endmodule

// ===== rtl/chs_pkg.sv
// Purpose: Types of the health status block.
// Assumes: Constants come from chs_regs.svh.
// Notes:   None.
package chs_pkg;
  typedef logic [7:0]  chs_byte_t;
  typedef logic [31:0] chs_word_t;
  typedef logic [3:0]  chs_addr_t;
  typedef enum logic [1:0] {
    CHS_BUS_IDLE,
    CHS_BUS_ACK
  } chs_bus_state_t;
endpackage

// ===== rtl/chs_regs.svh
// Purpose: Register offsets, field positions and reset values of the health status block.
// Assumes: Avalon-MM slave with 32-bit data, byte addresses in words of four.
// Notes:   Definitions only.
`ifndef CHS_REGS_SVH
`define CHS_REGS_SVH
`define CHS_ADDR_W          4
`define CHS_OFF_SUMMARY     4'h0
`define CHS_OFF_EVT_STAT    4'h4
`define CHS_OFF_EVT_MASK    4'h8
`define CHS_OFF_CONFIG      4'hC
`define CHS_BIT_IN_PWR      0
`define CHS_BIT_OUT_PWR     1
`define CHS_BIT_STD_ERR     2
`define CHS_BIT_STD_RUN     3
`define CHS_BIT_SAF_ERR     4
`define CHS_BIT_SAF_RUN     5
`define CHS_BIT_RUN_MODE    6
`define CHS_BIT_NORMAL      7
`define CHS_CFG_IN_USED     0
`define CHS_CFG_OUT_USED    1
`define CHS_CFG_DUAL_NET    2
`define CHS_CFG_SLAVE_ON    3
`define CHS_RST_BYTE        8'h00
`define CHS_RST_CFG         8'h03
`define CHS_UNMAPPED        32'h0000_0000
`define CHS_CONN_N          8
`define CHS_SYNC_FILL       3
`endif

// ===== tb/chs_remote_reader.sv
// Purpose: Remote reader that reaches the health status block over Avalon-MM.
// Assumes: One clock; the bench calls the access task between clock edges.
// Notes:   Each finished read raises rd_valid_out for one cycle.
`timescale 1ns/1ps
module chs_remote_reader (
  input  wire logic                clk_in,
  output chs_pkg::chs_addr_t       address_out,
  output logic                     read_out,
  output logic                     write_out,
  output chs_pkg::chs_word_t       writedata_out,
  output logic [3:0]               byteenable_out,
  input  wire chs_pkg::chs_word_t  readdata_in,
  input  wire logic                waitrequest_in,
  output logic                     rd_valid_out,
  output chs_pkg::chs_word_t       rd_data_out
);
  import chs_pkg::*;
  initial begin
    address_out = 4'h0;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0;
    byteenable_out = 4'h0;
    rd_valid_out = 1'b0;
    rd_data_out = 32'h0;
  end
  always @(posedge clk_in) begin
    if (rd_valid_out) begin
      rd_valid_out <= 1'b0;
    end
  end
  // Holds the request until waitrequest is seen low at a rising edge, for at most 64 edges.
  task automatic access(input logic wr, input chs_addr_t a, input chs_word_t d,
                        input logic [3:0] be, output bit ok);
    int n;
    @(posedge clk_in);
    address_out <= a;
    read_out <= ~wr;
    write_out <= wr;
    writedata_out <= d;
    byteenable_out <= be;
    ok = 1'b0;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk_in);
      if (waitrequest_in === 1'b0) begin
        ok = 1'b1;
      end
    end
    rd_data_out <= readdata_in;
    rd_valid_out <= ~wr & ok;
    read_out <= 1'b0;
    write_out <= 1'b0;
  endtask
endmodule

// ===== tb/tb_controller_general_status_byte.sv
// Purpose: Self-checking bench of the health status block.
// Assumes: Status inputs settle into the summary byte within five edges.
// Notes:   Read results are checked against a queue of expected words.
`timescale 1ns/1ps
`include "chs_regs.svh"
module tb_controller_general_status_byte;
  import chs_pkg::*;
  logic       core_clk_in = 1'b0;
  logic       rstn_in     = 1'b0;
  chs_addr_t  address;
  logic       rd, wr, waitreq, irq, rd_valid;
  chs_word_t  wdata, rdata, rd_data;
  logic [3:0] be;
  logic       in_ok = 1'b1, out_ok = 1'b1, run_mode = 1'b0;
  logic [7:0] a_est = 8'h0, a_err = 8'h0, b_est = 8'h0, b_err = 8'h0;
  logic [7:0] m_est = 8'h0, m_err = 8'h0, s_err = 8'h0;
  logic [15:0] err_det = 16'h0;
  chs_byte_t  health;
  chs_word_t  exp_q[$];
  int         fails = 0, checks_done = 0;
  logic [3:0] cfg_tab [4] = '{4'h3, 4'h7, 4'hB, 4'hC};
  always #2.5 core_clk_in = ~core_clk_in;
  chs_health_status dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .input_supply_ok_in(in_ok),
    .output_supply_ok_in(out_ok), .std_a_estab_in(a_est), .std_a_err_in(a_err),
    .std_b_estab_in(b_est), .std_b_err_in(b_err), .saf_m_estab_in(m_est),
    .saf_m_err_in(m_err), .saf_s_err_in(s_err), .run_mode_in(run_mode),
    .error_detail_in(err_det), .health_byte_out(health), .irq_out(irq));
  chs_remote_reader peer (.clk_in(core_clk_in), .address_out(address), .read_out(rd),
    .write_out(wr), .writedata_out(wdata), .byteenable_out(be), .readdata_in(rdata),
    .waitrequest_in(waitreq), .rd_valid_out(rd_valid), .rd_data_out(rd_data));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic compare(input string what, input chs_word_t e, input chs_word_t s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  always @(posedge core_clk_in) begin
    if (rd_valid === 1'b1) begin
      compare("readdata", exp_q.pop_front(), rd_data);
    end
  end
  task automatic bus(input logic w, input chs_addr_t a, input chs_word_t d,
                     input logic [3:0] b);
    bit ok;
    peer.access(w, a, d, b, ok);
    if (!ok) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic rd_chk(input chs_addr_t a, input chs_word_t e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  // Expected summary byte from the current inputs and configuration.
  function automatic chs_byte_t model(input logic [3:0] c);
    logic ra, rb, ms;
    ra = (|a_est) & ~(|a_err);
    rb = (|b_est) & ~(|b_err);
    ms = c[3] & (|s_err);
    model = {~(|err_det), run_mode, (|m_est) & ~(|m_err) & ~ms, (|m_err) | ms,
             c[2] ? (ra & rb) : ra, (|a_err) | (c[2] & (|b_err)),
             c[1] & ~out_ok, c[0] & ~in_ok};
  endfunction
  task automatic shake();
    @(posedge core_clk_in);
    in_ok <= 1'($urandom);
    out_ok <= 1'($urandom);
    run_mode <= 1'($urandom);
    a_est <= 8'($urandom);
    b_est <= 8'($urandom);
    m_est <= 8'($urandom);
    a_err <= ($urandom % 2) ? 8'h00 : 8'($urandom);
    b_err <= ($urandom % 2) ? 8'h00 : 8'($urandom);
    m_err <= ($urandom % 2) ? 8'h00 : 8'($urandom);
    s_err <= ($urandom % 2) ? 8'h00 : 8'($urandom);
    err_det <= ($urandom % 2) ? 16'h0000 : 16'($urandom);
    repeat (5) @(posedge core_clk_in);
  endtask
  initial begin
    void'($urandom(32'hFCBFEEF3));
    repeat (5) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    rd_chk(`CHS_OFF_CONFIG, 32'h0000_0003);
    rd_chk(4'h6, `CHS_UNMAPPED);
    bus(1'b1, `CHS_OFF_SUMMARY, 32'h0000_00FF, 4'hF);
    $display("test reset and map done");
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `CHS_OFF_CONFIG, {28'h0, cfg_tab[c]}, 4'hF);
      bus(1'b1, `CHS_OFF_CONFIG, 32'h0000_0000, 4'h0);
      for (int k = 0; k < 8; k++) begin
        shake();
        rd_chk(`CHS_OFF_SUMMARY, {24'h0, model(cfg_tab[c])});
        compare("health", {24'h0, model(cfg_tab[c])}, {24'h0, health});
        @(posedge core_clk_in);
        compare("health", {24'h0, model(cfg_tab[c])}, rd_data);
      end
      $display("test config %h done", cfg_tab[c]);
    end
    bus(1'b1, `CHS_OFF_CONFIG, 32'h0000_0003, 4'hF);
    repeat (5) @(posedge core_clk_in);
    bus(1'b1, `CHS_OFF_EVT_STAT, 32'h0000_00FF, 4'hF);
    rd_chk(`CHS_OFF_EVT_STAT, 32'h0000_0000);
    bus(1'b1, `CHS_OFF_EVT_MASK, 32'h0000_0001, 4'hF);
    compare("irq", 32'h0, {31'h0, irq});
    @(posedge core_clk_in);
    in_ok <= ~in_ok;
    repeat (6) @(posedge core_clk_in);
    compare("irq", 32'h1, {31'h0, irq});
    rd_chk(`CHS_OFF_EVT_STAT, 32'h0000_0001);
    bus(1'b1, `CHS_OFF_EVT_MASK, 32'h0000_0000, 4'hF);
    repeat (2) @(posedge core_clk_in);
    compare("irq", 32'h0, {31'h0, irq});
    bus(1'b1, `CHS_OFF_EVT_STAT, 32'h0000_0001, 4'hF);
    rd_chk(`CHS_OFF_EVT_STAT, 32'h0000_0000);
    bus(1'b1, `CHS_OFF_EVT_MASK, 32'h0000_00FF, 4'hF);
    repeat (2) @(posedge core_clk_in);
    compare("irq", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    repeat (3) @(posedge core_clk_in);
    give_verdict();
  end
endmodule
